// ### dv/alsu_regfile_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// destination register of the register file, written back
// ------------------------------------------------------------
module alsu_regfile_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic rsp_valid,
   input wire alsu_pkg::alsu_rsp_t rsp,
   output logic [15:0] dst_r
);
   // a stray response lands here, so refused requests show up as corruption
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dst_r <= 16'h0000;
      end else if (load) begin
         dst_r <= load_val;
      end else if (rsp_valid && rsp.wr_word) begin
         dst_r <= rsp.result;
      end else if (rsp_valid && rsp.wr_byte) begin
         dst_r[7:0] <= rsp.result[7:0];
      end
   end
endmodule

// ### dv/cpu_arith_logic_shift_unit_tb.sv
`timescale 1ns/10ps
module cpu_arith_logic_shift_unit_tb;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic req_valid = 1'b0;
   logic load = 1'b0;
   alsu_pkg::alsu_req_t req = '0;
   logic busy;
   logic rsp_valid;
   alsu_pkg::alsu_rsp_t rsp;
   logic [15:0] dst_r;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [31:0] seed = 32'h00000027;

   always #20 clk = ~clk;

   alsu_core alsu_core_inst (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
      .busy(busy), .rsp_valid(rsp_valid), .rsp(rsp));
   alsu_regfile_model alsu_regfile_model_inst (.clk(clk), .reset_n(reset_n), .load(load),
      .load_val(req.dst), .rsp_valid(rsp_valid), .rsp(rsp), .dst_r(dst_r));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic alsu_pkg::alsu_rsp_t exp_f(input alsu_pkg::alsu_req_t r);
      alsu_pkg::alsu_rsp_t e;
      logic [7:0] d;
      logic [7:0] s;
      logic [7:0] o;
      logic [8:0] w;
      logic [16:0] ww;
      logic [15:0] q;
      logic [15:0] rm;
      logic [4:0] hl;
      logic bw;
      e = '0;
      d = r.dst[7:0];
      s = r.use_imm ? r.imm : r.src[7:0];
      o = d;
      bw = 1'b1;
      e.flags = r.flags;
      e.result = r.dst;
      e.wr_byte = 1'b1;
      case (r.op)
         alsu_pkg::ALSU_OP_DECIMAL_ADJUST_SUB: begin
            o = d - (r.flags.h ? 8'h06 : 8'h00) - (r.flags.c ? 8'h60 : 8'h00);
         end
         alsu_pkg::ALSU_OP_UNSIGNED_MULTIPLY: begin
            e.result = {8'h00, d} * {8'h00, r.src[7:0]};
            bw = 1'b0;
         end
         alsu_pkg::ALSU_OP_UNSIGNED_DIVIDE: begin
            q = r.dst / {8'h00, r.src[7:0]};
            rm = r.dst % {8'h00, r.src[7:0]};
            e.result = {rm[7:0], q[7:0]};
            e.flags.z = (r.src[7:0] == 8'h00);
            bw = 1'b0;
         end
         alsu_pkg::ALSU_OP_COMPARE_B, alsu_pkg::ALSU_OP_TWOS_COMPLEMENT: begin
            if (r.op == alsu_pkg::ALSU_OP_TWOS_COMPLEMENT) begin
               s = d;
               d = 8'h00;
            end
            hl = {1'b0, d[3:0]} - {1'b0, s[3:0]};
            e.flags.h = hl[4];
            w = {1'b0, d} - {1'b0, s};
            o = w[7:0];
            e.flags.c = w[8];
            e.flags.v = (d[7] ^ s[7]) & (d[7] ^ o[7]);
            e.wr_byte = (r.op == alsu_pkg::ALSU_OP_TWOS_COMPLEMENT);
         end
         alsu_pkg::ALSU_OP_COMPARE_W: begin
            ww = {1'b0, r.dst} - {1'b0, r.src};
            e.flags.n = ww[15];
            e.flags.z = (ww[15:0] == 16'h0000);
            e.flags.c = ww[16];
            e.flags.v = (r.dst[15] ^ r.src[15]) & (r.dst[15] ^ ww[15]);
            e.wr_byte = 1'b0;
            bw = 1'b0;
         end
         alsu_pkg::ALSU_OP_AND: o = d & s;
         alsu_pkg::ALSU_OP_OR: o = d | s;
         alsu_pkg::ALSU_OP_XOR: o = d ^ s;
         alsu_pkg::ALSU_OP_NOT: o = ~d;
         alsu_pkg::ALSU_OP_ARITH_SHIFT_LEFT,
         alsu_pkg::ALSU_OP_LOGIC_SHIFT_LEFT: o = {d[6:0], 1'b0};
         alsu_pkg::ALSU_OP_ARITH_SHIFT_RIGHT: o = {d[7], d[7:1]};
         alsu_pkg::ALSU_OP_LOGIC_SHIFT_RIGHT: o = {1'b0, d[7:1]};
         alsu_pkg::ALSU_OP_ROTATE_LEFT: o = {d[6:0], d[7]};
         alsu_pkg::ALSU_OP_ROTATE_RIGHT: o = {d[0], d[7:1]};
         alsu_pkg::ALSU_OP_ROTATE_LEFT_THROUGH_CARRY: o = {d[6:0], r.flags.c};
         alsu_pkg::ALSU_OP_ROTATE_RIGHT_THROUGH_CARRY: o = {r.flags.c, d[7:1]};
         default: begin
            e.wr_byte = 1'b0;
            bw = 1'b0;
         end
      endcase
      if (r.op >= alsu_pkg::ALSU_OP_AND) begin
         e.flags.v = (r.op == alsu_pkg::ALSU_OP_ARITH_SHIFT_LEFT) ? d[7] ^ d[6] : 1'b0;
      end
      if (r.op >= alsu_pkg::ALSU_OP_ARITH_SHIFT_LEFT) begin
         e.flags.c = r.op[0] ? d[7] : d[0];
      end
      if (bw) begin
         e.result[7:0] = o;
         e.flags.n = o[7];
         e.flags.z = (o == 8'h00);
      end
      if (r.op == alsu_pkg::ALSU_OP_UNSIGNED_DIVIDE
          || r.op == alsu_pkg::ALSU_OP_UNSIGNED_MULTIPLY) begin
         e.wr_word = 1'b1;
         e.wr_byte = 1'b0;
      end
      return e;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // one operation; poke offers a second request while busy
   // ------------------------------------------------------------
   task automatic run(input alsu_pkg::alsu_req_t r, input bit poke);
      alsu_pkg::alsu_rsp_t e;
      alsu_pkg::alsu_rsp_t got;
      logic [15:0] m;
      logic [15:0] wb;
      logic dv;
      logic dz;
      int lat;
      int nbusy;
      int npulse;
      e = exp_f(r);
      dv = (r.op == alsu_pkg::ALSU_OP_UNSIGNED_DIVIDE);
      dz = dv && (r.src[7:0] == 8'h00);
      m = 16'hFFFF;
      if (dz || r.op <= alsu_pkg::ALSU_OP_NONE || r.op == alsu_pkg::ALSU_OP_COMPARE_B
          || r.op == alsu_pkg::ALSU_OP_COMPARE_W) begin
         m = 16'h0000;
      end
      wb = e.wr_word ? e.result : (e.wr_byte ? {r.dst[15:8], e.result[7:0]} : r.dst);
      lat = 0;
      nbusy = 0;
      npulse = 0;
      got = '0;
      @(negedge clk);
      req = r;
      req_valid = 1'b1;
      load = 1'b1;
      for (int k = 1; k <= 12; k++) begin
         @(negedge clk);
         if (k == 1) begin
            req_valid = 1'b0;
            load = 1'b0;
         end
         if (poke && k == 3) begin
            req.op = alsu_pkg::ALSU_OP_NOT;
            req_valid = 1'b1;
         end
         if (poke && k == 4) begin
            req_valid = 1'b0;
         end
         if (busy === 1'b1) nbusy++;
         if (rsp_valid === 1'b1) begin
            npulse++;
            lat = k;
            got = rsp;
         end
      end
      check(npulse, 1);
      check(lat, dv ? 9 : 1);
      check(nbusy, dv ? 8 : 0);
      check(32'(got.result & m), 32'(e.result & m));
      check(32'(got[6:0]), 32'(e[6:0]));
      if (!dz) check(dst_r, wb);
   endtask

   // hang guard, well above the ~3000 cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         final_report();
      end
   end

   initial begin
      alsu_pkg::alsu_req_t r;
      logic [31:0] t;
      repeat (4) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      for (int i = 0; i < 228; i++) begin
         t = rnd();
         r.op = alsu_pkg::alsu_op_t'(i % 19);
         r.dst = t[15:0];
         r.src = t[31:16];
         t = rnd();
         r.imm = t[7:0];
         r.use_imm = t[8];
         r.flags = t[13:9];
         // sign-bit and zero operands first
         if (i < 19) r.dst[7:0] = 8'h80;
         else if (i < 38) r.dst[7:0] = 8'h00;
         if (r.op == alsu_pkg::ALSU_OP_UNSIGNED_DIVIDE) begin
            r.use_imm = 1'b0;
            if (r.src[7:0] == 8'h00) r.src[7:0] = 8'h01;
            r.dst[15:8] = r.dst[15:8] % r.src[7:0];
         end
         run(r, 1'b0);
      end
      r.op = alsu_pkg::ALSU_OP_UNSIGNED_DIVIDE;
      r.use_imm = 1'b0;
      r.dst = 16'h12FF;
      r.src = 16'h0056;
      run(r, 1'b1);
      r.src = 16'h0000;
      run(r, 1'b0);
      final_report();
   end
endmodule

// ### logic/alsu_core.sv
`timescale 1ns/10ps
// Functional notes
// - decimal adjust after subtract using carry, half-carry
// - 8x8 unsigned multiply gives 16-bit product
// - 16/8 unsigned divide, quotient and remainder
// - compare sets flags only, destination untouched
// - compare byte or word; immediate byte only
// - negate byte: zero minus destination
// - AND byte with register or immediate
// - OR byte with register or immediate
// - XOR byte with register or immediate
// - NOT inverts every bit of the destination low byte
// - arithmetic right shift keeps sign, shift-out to carry
// - logical shifts zero fill, shift-out to carry
// - plain rotates, wrapped bit copied to carry
// - rotate through carry as nine-bit ring
module alsu_core (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic req_valid,
   input wire alsu_pkg::alsu_req_t req,
   output logic busy,
   output logic rsp_valid,
   output alsu_pkg::alsu_rsp_t rsp
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic alsu_pkg::alsu_flags_t sub_flags8(input logic [7:0] a, input logic [7:0] b,
                                                       input alsu_pkg::alsu_flags_t f);
      alsu_pkg::alsu_flags_t r;
      logic [8:0] d;
      logic [4:0] dl;
      r = f;
      d = {1'b0, a} - {1'b0, b};
      dl = {1'b0, a[3:0]} - {1'b0, b[3:0]};
      r.n = d[7];
      r.z = (d[7:0] == 8'h00);
      r.v = (a[7] ^ b[7]) & (a[7] ^ d[7]);
      r.c = d[8];
      r.h = dl[4];
      return r;
   endfunction

   // ------------------------------------------------------------
   // single-cycle result
   // ------------------------------------------------------------
   logic [7:0] a8;
   logic [7:0] b8;
   logic [15:0] res_nxt;
   logic wr_word_nxt;
   logic wr_byte_nxt;
   logic start_div;
   alsu_pkg::alsu_flags_t fl_nxt;

   always_comb begin
      logic [16:0] dw;
      logic [7:0] fix;
      dw = 17'h00000;
      fix = 8'h00;
      a8 = req.dst[7:0];
      b8 = req.use_imm ? req.imm : req.src[7:0];
      res_nxt = req.dst;
      wr_word_nxt = 1'b0;
      wr_byte_nxt = 1'b0;
      start_div = 1'b0;
      fl_nxt = req.flags;
      case (req.op)
         alsu_pkg::ALSU_OP_DECIMAL_ADJUST_SUB: begin
            // borrow flags select the correction digits
            fix = req.flags.h ? alsu_pkg::ALSU_DEC_ADJ_LO_FIX : 8'h00;
            fix = fix | (req.flags.c ? alsu_pkg::ALSU_DEC_ADJ_HI_FIX : 8'h00);
            res_nxt[7:0] = a8 - fix;
            wr_byte_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_UNSIGNED_MULTIPLY: begin
            res_nxt = {8'h00, a8} * {8'h00, req.src[7:0]};
            wr_word_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_UNSIGNED_DIVIDE: begin
            start_div = 1'b1;
         end
         alsu_pkg::ALSU_OP_COMPARE_B: begin
            fl_nxt = sub_flags8(a8, b8, req.flags);
         end
         alsu_pkg::ALSU_OP_COMPARE_W: begin
            // word form always takes the source register, never immediate
            dw = {1'b0, req.dst} - {1'b0, req.src};
            fl_nxt.n = dw[15];
            fl_nxt.z = (dw[15:0] == 16'h0000);
            fl_nxt.v = (req.dst[15] ^ req.src[15]) & (req.dst[15] ^ dw[15]);
            fl_nxt.c = dw[16];
         end
         alsu_pkg::ALSU_OP_TWOS_COMPLEMENT: begin
            res_nxt[7:0] = 8'h00 - a8;
            wr_byte_nxt = 1'b1;
            fl_nxt = sub_flags8(8'h00, a8, req.flags);
         end
         alsu_pkg::ALSU_OP_AND: begin
            res_nxt[7:0] = a8 & b8;
            wr_byte_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_OR: begin
            res_nxt[7:0] = a8 | b8;
            wr_byte_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_XOR: begin
            res_nxt[7:0] = a8 ^ b8;
            wr_byte_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_NOT: begin
            res_nxt[7:0] = ~a8;
            wr_byte_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_ARITH_SHIFT_LEFT: begin
            res_nxt[7:0] = {a8[6:0], 1'b0};
            fl_nxt.c = a8[7];
            fl_nxt.v = a8[7] ^ a8[6];
            wr_byte_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_ARITH_SHIFT_RIGHT: begin
            res_nxt[7:0] = {a8[7], a8[7:1]};
            fl_nxt.c = a8[0];
            wr_byte_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_LOGIC_SHIFT_LEFT: begin
            res_nxt[7:0] = {a8[6:0], 1'b0};
            fl_nxt.c = a8[7];
            wr_byte_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_LOGIC_SHIFT_RIGHT: begin
            res_nxt[7:0] = {1'b0, a8[7:1]};
            fl_nxt.c = a8[0];
            wr_byte_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_ROTATE_LEFT: begin
            res_nxt[7:0] = {a8[6:0], a8[7]};
            fl_nxt.c = a8[7];
            wr_byte_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_ROTATE_RIGHT: begin
            res_nxt[7:0] = {a8[0], a8[7:1]};
            fl_nxt.c = a8[0];
            wr_byte_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_ROTATE_LEFT_THROUGH_CARRY: begin
            res_nxt[7:0] = {a8[6:0], req.flags.c};
            fl_nxt.c = a8[7];
            wr_byte_nxt = 1'b1;
         end
         alsu_pkg::ALSU_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
            res_nxt[7:0] = {req.flags.c, a8[7:1]};
            fl_nxt.c = a8[0];
            wr_byte_nxt = 1'b1;
         end
         default: begin
            res_nxt = req.dst;
         end
      endcase
      // logic ops keep carry; of the shifts only arithmetic left sets overflow
      if (req.op inside {[alsu_pkg::ALSU_OP_AND:alsu_pkg::ALSU_OP_NOT],
                         [alsu_pkg::ALSU_OP_ARITH_SHIFT_RIGHT:
                          alsu_pkg::ALSU_OP_ROTATE_RIGHT_THROUGH_CARRY]}) begin
         fl_nxt.v = 1'b0;
      end
      if (wr_byte_nxt) begin
         fl_nxt.n = res_nxt[7];
         fl_nxt.z = (res_nxt[7:0] == 8'h00);
      end
   end

   // ------------------------------------------------------------
   // restoring divider, fixed eight steps
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ALSU_ST_IDLE,
      ALSU_ST_DIV
   } alsu_state_t;

   alsu_state_t state_r;
   logic [3:0] cnt_r;
   logic [7:0] rem_r;
   logic [7:0] quo_r;
   logic [7:0] dvs_r;
   alsu_pkg::alsu_flags_t dflags_r;
   logic [8:0] trial;
   logic [8:0] shifted;
   logic step_sub;

   // a zero divisor simply never subtracts less; count still ends the op
   always_comb begin
      shifted = {rem_r, quo_r[7]};
      trial = shifted - {1'b0, dvs_r};
      // remainder top bit set means the shifted value already exceeds the divisor
      step_sub = !trial[8] || rem_r[7];
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ALSU_ST_IDLE;
         cnt_r <= 4'h0;
         rem_r <= 8'h00;
         quo_r <= 8'h00;
         dvs_r <= 8'h00;
         dflags_r <= '0;
      end else begin
         case (state_r)
            ALSU_ST_IDLE: begin
               if (req_valid && start_div) begin
                  state_r <= ALSU_ST_DIV;
                  cnt_r <= 4'h0;
                  rem_r <= req.dst[15:8];
                  quo_r <= req.dst[7:0];
                  dvs_r <= req.src[7:0];
                  dflags_r <= req.flags;
               end
            end
            ALSU_ST_DIV: begin
               // quotient bits shift into quo_r as dividend bits leave
               rem_r <= step_sub ? trial[7:0] : shifted[7:0];
               quo_r <= {quo_r[6:0], step_sub};
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == alsu_pkg::ALSU_DIV_CNT_LAST) begin
                  state_r <= ALSU_ST_IDLE;
               end
            end
            default: begin
               state_r <= ALSU_ST_IDLE;
            end
         endcase
      end
   end

   logic div_done;
   assign div_done = (state_r == ALSU_ST_DIV) && (cnt_r == alsu_pkg::ALSU_DIV_CNT_LAST);

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
         rsp <= '0;
         busy <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (div_done) begin
            rsp_valid <= 1'b1;
            busy <= 1'b0;
            rsp.wr_word <= 1'b1;
            rsp.wr_byte <= 1'b0;
            rsp.result <= {step_sub ? trial[7:0] : shifted[7:0], quo_r[6:0], step_sub};
            rsp.flags <= dflags_r;
            rsp.flags.z <= (dvs_r == 8'h00);
         end else if (req_valid && state_r == ALSU_ST_IDLE) begin
            if (start_div) begin
               busy <= 1'b1;
            end else begin
               rsp_valid <= 1'b1;
               rsp.result <= res_nxt;
               rsp.wr_word <= wr_word_nxt;
               rsp.wr_byte <= wr_byte_nxt;
               rsp.flags <= fl_nxt;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_div_start;
      req_valid && !busy && state_r == ALSU_ST_IDLE
         && req.op == alsu_pkg::ALSU_OP_UNSIGNED_DIVIDE;
   endsequence

   property p_div_time;
      @(posedge clk) disable iff (!reset_n)
      s_div_start |=> busy [*8] ##1 rsp_valid;
   endproperty
   a_div_time: assert property (p_div_time) else $error("divide latency wrong");

   property p_compare_nowrite;
      @(posedge clk) disable iff (!reset_n)
      (req_valid && !busy && req.op == alsu_pkg::ALSU_OP_COMPARE_B)
         |=> rsp_valid && !rsp.wr_byte && !rsp.wr_word;
   endproperty
   a_compare_nowrite: assert property (p_compare_nowrite) else $error("compare wrote dest");

   property p_mul;
      @(posedge clk) disable iff (!reset_n)
      (req_valid && !busy && req.op == alsu_pkg::ALSU_OP_UNSIGNED_MULTIPLY)
         |=> rsp.result == $past(req.dst[7:0]) * $past(req.src[7:0]) && rsp.wr_word;
   endproperty
   a_mul: assert property (p_mul) else $error("multiply product wrong");

   property p_negate;
      @(posedge clk) disable iff (!reset_n)
      (req_valid && !busy && req.op == alsu_pkg::ALSU_OP_TWOS_COMPLEMENT)
         |=> rsp.result[7:0] + $past(req.dst[7:0]) == 8'h00;
   endproperty
   a_negate: assert property (p_negate) else $error("negate wrong");

   property p_not;
      @(posedge clk) disable iff (!reset_n)
      (req_valid && !busy && req.op == alsu_pkg::ALSU_OP_NOT)
         |=> (rsp.result[7:0] ^ $past(req.dst[7:0])) == 8'hFF && !rsp.flags.v;
   endproperty
   a_not: assert property (p_not) else $error("complement wrong");

   property p_sar;
      @(posedge clk) disable iff (!reset_n)
      (req_valid && !busy && req.op == alsu_pkg::ALSU_OP_ARITH_SHIFT_RIGHT)
         |=> rsp.result[7] == $past(req.dst[7]) && rsp.flags.c == $past(req.dst[0]);
   endproperty
   a_sar: assert property (p_sar) else $error("arith shift right wrong");

   property p_rxl;
      @(posedge clk) disable iff (!reset_n)
      (req_valid && !busy && req.op == alsu_pkg::ALSU_OP_ROTATE_LEFT_THROUGH_CARRY)
         |=> rsp.result[0] == $past(req.flags.c) && rsp.flags.c == $past(req.dst[7]);
   endproperty
   a_rxl: assert property (p_rxl) else $error("rotate through carry wrong");

   property p_and_c;
      @(posedge clk) disable iff (!reset_n)
      (req_valid && !busy && req.op == alsu_pkg::ALSU_OP_AND)
         |=> rsp.flags.c == $past(req.flags.c) && rsp.wr_byte;
   endproperty
   a_and_c: assert property (p_and_c) else $error("and touched carry");

endmodule

// ### logic/alsu_pkg.sv
package alsu_pkg;
   // ------------------------------------------------------------
   // operation codes
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      ALSU_OP_NONE,
      ALSU_OP_DECIMAL_ADJUST_SUB,
      ALSU_OP_UNSIGNED_MULTIPLY,
      ALSU_OP_UNSIGNED_DIVIDE,
      ALSU_OP_COMPARE_B,
      ALSU_OP_COMPARE_W,
      ALSU_OP_TWOS_COMPLEMENT,
      ALSU_OP_AND,
      ALSU_OP_OR,
      ALSU_OP_XOR,
      ALSU_OP_NOT,
      ALSU_OP_ARITH_SHIFT_LEFT,
      ALSU_OP_ARITH_SHIFT_RIGHT,
      ALSU_OP_LOGIC_SHIFT_LEFT,
      ALSU_OP_LOGIC_SHIFT_RIGHT,
      ALSU_OP_ROTATE_LEFT,
      ALSU_OP_ROTATE_RIGHT,
      ALSU_OP_ROTATE_LEFT_THROUGH_CARRY,
      ALSU_OP_ROTATE_RIGHT_THROUGH_CARRY
   } alsu_op_t;

   // ------------------------------------------------------------
   // condition_flags layout (h n z v c)
   // ------------------------------------------------------------
   typedef struct packed {
      logic h;
      logic n;
      logic z;
      logic v;
      logic c;
   } alsu_flags_t;

   typedef struct packed {
      alsu_op_t op;
      logic use_imm;
      logic [15:0] dst;
      logic [15:0] src;
      logic [7:0] imm;
      alsu_flags_t flags;
   } alsu_req_t;

   typedef struct packed {
      logic [15:0] result;
      logic wr_word;
      logic wr_byte;
      alsu_flags_t flags;
   } alsu_rsp_t;

   localparam int unsigned ALSU_DIV_STEPS = 8;
   localparam logic [3:0] ALSU_DIV_CNT_LAST = 4'h7;
   localparam logic [7:0] ALSU_DEC_ADJ_LO_FIX = 8'h06;
   localparam logic [7:0] ALSU_DEC_ADJ_HI_FIX = 8'h60;
endpackage
